// file: hw/ebs_status.sv
// Emulation breakpoint status register: sticky breakpoint hits and mailbox state, read by the core
//
// How it works
// - A program-memory data breakpoint hit sets bit 0, which is 0 until one occurs.
// - Data-memory breakpoint hits set bit 1 for comparator zero and bit 2 for comparator one.
// - Instruction-address comparators zero to three set bits 3 to 6 in ascending order.
// - A breakpoint match on the peripheral DMA bus sets bit 7.
// - A match on the external-port DMA bus sets bit 16, which is reserved where that bus is absent.
// - Breakpoint-hit bits are set only by the comparators and nothing clears them but reset.
// - Bit 9 is the low-priority output-FIFO interrupt enable, written by the core.
// - Bit 10 is 1 while the output FIFO holds data and 0 when empty, as the FIFO controller says.
// - Bit 11 is 1 while the output FIFO is full, as the FIFO controller says.
// - Bit 12 is 1 while the emulation input register holds a value.
// - Bit 13 is 1 when the enhanced emulation feature is disabled and 0 when enabled.
// - Bit 15 is 1 when the input-register interrupt is enabled.
// - Bits 12, 13 and 15 follow internal hardware and ignore core writes.
// - The register sits in the core's memory-mapped I/O space and reads return its registered state one cycle after the access.
`timescale 1ns/1ps
`default_nettype none
`include "ebs_defines.svh"

module ebs_status (
   input wire logic clk,
   input wire logic arst_n,

   // Hit pulses from the breakpoint comparators
   input wire logic pmDataBkptHit,
   input wire logic dmAddr0BkptHit,
   input wire logic dmAddr1BkptHit,
   input wire logic instrAddr0BkptHit,
   input wire logic instrAddr1BkptHit,
   input wire logic instrAddr2BkptHit,
   input wire logic instrAddr3BkptHit,
   input wire logic periphDmaBkptHit,
   input wire logic extportDmaBkptHit,

   // Levels from the mailbox FIFO controller and emulation logic
   input wire logic outFifoHasData,
   input wire logic outFifoFull,
   input wire logic inRegFull,
   input wire logic emuFeatureDisable,
   input wire logic inRegIrqEnable,

   // Core memory-mapped I/O access
   input wire logic coreRdEn,
   input wire logic coreWrEn,
   input wire logic [`EBS_ADDR_W-1:0] coreAddr,
   input wire logic [`EBS_DATA_W-1:0] coreWrData,
   output logic [`EBS_DATA_W-1:0] coreRdData,
   output logic coreRdValid,
   output logic coreWrAck,

   // Enable handed to the interrupt controller
   output logic outFifoIrqEnable
);

   // Register state and its next value
   ebs_pkg::ebs_state_t state_r;
   ebs_pkg::ebs_state_t state_nxt;

   // Hit inputs gathered into one vector, lowest status bit first
   logic [`EBS_HIT_COUNT-1:0] hitIn;
   logic [`EBS_HIT_COUNT-1:0] hitMask;
   logic [`EBS_HIT_COUNT-1:0] hitSet;
   logic [`EBS_HIT_COUNT-1:0] hitSticky;

   // Mailbox levels in status-bit order
   logic outLvl;
   logic fullLvl;
   logic inFullLvl;
   logic featDisLvl;
   logic inIrqLvl;

   // Decoded core access
   logic addrMatch;
   logic rdStatus;
   logic rdOther;
   logic wrStatus;
   logic outIrqEnWr;
   logic [`EBS_DATA_W-1:0] rdImage;

   // True when the core addresses this register
   function automatic logic ebs_hit_addr(input logic [`EBS_ADDR_W-1:0] addr);
      ebs_hit_addr = (addr == `EBS_STATUS_ADDR);
   endfunction : ebs_hit_addr

   // Keeps only the core-writable field of a write word
   function automatic logic ebs_wr_field(input logic [`EBS_DATA_W-1:0] data);
      logic [`EBS_DATA_W-1:0] kept;
      kept = data & `EBS_WRITABLE_MASK;
      ebs_wr_field = kept[`EBS_POS_OUT_IRQ_EN];
   endfunction : ebs_wr_field

   // Packs the state into the register image; unlisted positions stay zero
   function automatic logic [`EBS_DATA_W-1:0] ebs_image(input ebs_pkg::ebs_state_t s);
      logic [`EBS_DATA_W-1:0] w;
      w = `EBS_STATUS_RESET;

      // Breakpoint hits
      w[`EBS_POS_PM_DATA] = s.hit[0];
      w[`EBS_POS_DM_ADDR0] = s.hit[1];
      w[`EBS_POS_DM_ADDR1] = s.hit[2];
      w[`EBS_POS_INSTR_ADDR0 +: 4] = s.hit[6:3];
      w[`EBS_POS_PERIPH_DMA] = s.hit[7];
      w[`EBS_POS_EXTPORT_DMA] = s.hit[8];

      // Mailbox state
      w[`EBS_POS_OUT_IRQ_EN] = s.outIrqEn;
      w[`EBS_POS_OUT_HAS_DATA] = s.outHasData;
      w[`EBS_POS_OUT_FULL] = s.outFull;
      w[`EBS_POS_IN_FULL] = s.inFull;
      w[`EBS_POS_FEAT_DIS] = s.featDis;
      w[`EBS_POS_IN_IRQ_EN] = s.inIrqEn;

      ebs_image = w;
   endfunction : ebs_image

   // Hit sources in status order
   assign hitIn[0] = pmDataBkptHit;
   assign hitIn[1] = dmAddr0BkptHit;
   assign hitIn[2] = dmAddr1BkptHit;
   assign hitIn[3] = instrAddr0BkptHit;
   assign hitIn[4] = instrAddr1BkptHit;
   assign hitIn[5] = instrAddr2BkptHit;
   assign hitIn[6] = instrAddr3BkptHit;
   assign hitIn[7] = periphDmaBkptHit;
   assign hitIn[8] = extportDmaBkptHit;

   // Without the external-port bus its hit can never be recorded
   assign hitMask = {`EBS_HAS_EXTPORT_DMA, {(`EBS_HIT_COUNT-1){1'b1}}};

   // One sticky cell per source; no clear path exists, so a set can never lose
   for (genvar g = 0; g < `EBS_HIT_COUNT; g++) begin : g_hit
      assign hitSet[g] = hitIn[g] & hitMask[g];
      assign hitSticky[g] = state_r.hit[g] | hitSet[g];
   end

   // Mailbox levels are already on this clock, so they are copied without synchronisers
   assign outLvl = outFifoHasData;
   assign fullLvl = outFifoFull;
   assign inFullLvl = inRegFull;
   assign featDisLvl = emuFeatureDisable;
   assign inIrqLvl = inRegIrqEnable;

   // Core access decode
   assign addrMatch = ebs_hit_addr(coreAddr);
   assign rdStatus = coreRdEn & addrMatch;
   assign rdOther = coreRdEn & ~addrMatch;
   assign wrStatus = coreWrEn & addrMatch;
   assign outIrqEnWr = ebs_wr_field(coreWrData);
   assign rdImage = ebs_image(state_r);

   always_comb begin
      state_nxt = state_r;

      // Sticky hit bits
      state_nxt.hit = hitSticky;

      // Mailbox levels, one cycle behind their sources and never core-written
      state_nxt.outHasData = outLvl;
      state_nxt.outFull = fullLvl;
      state_nxt.inFull = inFullLvl;
      state_nxt.featDis = featDisLvl;
      state_nxt.inIrqEn = inIrqLvl;

      // Only the output-FIFO interrupt enable takes write data
      state_nxt.wrAck = wrStatus;
      if (wrStatus) begin
         state_nxt.outIrqEn = outIrqEnWr;
      end

      // A read returns the image as it stood at the access edge; other addresses read zero
      state_nxt.rdValid = coreRdEn;
      if (rdStatus) begin
         state_nxt.rdData = rdImage;
      end else if (rdOther) begin
         state_nxt.rdData = `EBS_STATUS_RESET;
      end
   end

   // Whole state in one register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs come straight from flops
   assign coreRdData = state_r.rdData;
   assign coreRdValid = state_r.rdValid;
   assign coreWrAck = state_r.wrAck;
   assign outFifoIrqEnable = state_r.outIrqEn;

endmodule : ebs_status
`default_nettype wire

// file: hw/ebs_defines.svh
// Offsets, field positions, reset values and sizes of the emulation breakpoint status register
`ifndef EBS_DEFINES_SVH
`define EBS_DEFINES_SVH

`define EBS_ADDR_W 20
`define EBS_DATA_W 32
`define EBS_STATUS_ADDR 20'h30030
`define EBS_HIT_COUNT 9
`define EBS_HAS_EXTPORT_DMA 1'b1

`define EBS_POS_PM_DATA 0
`define EBS_POS_DM_ADDR0 1
`define EBS_POS_DM_ADDR1 2
`define EBS_POS_INSTR_ADDR0 3
`define EBS_POS_PERIPH_DMA 7
`define EBS_POS_OUT_IRQ_EN 9
`define EBS_POS_OUT_HAS_DATA 10
`define EBS_POS_OUT_FULL 11
`define EBS_POS_IN_FULL 12
`define EBS_POS_FEAT_DIS 13
`define EBS_POS_IN_IRQ_EN 15
`define EBS_POS_EXTPORT_DMA 16

`define EBS_HIT_RESET 9'h000
`define EBS_STATUS_RESET 32'h0000_0000
`define EBS_WRITABLE_MASK 32'h0000_0200

`endif

// file: hw/ebs_pkg.sv
// Types shared by the emulation breakpoint status register
`include "ebs_defines.svh"

package ebs_pkg;

   // Whole state of the status block, registered as one vector
   typedef struct packed {
      logic [`EBS_HIT_COUNT-1:0] hit;
      logic outIrqEn;
      logic outHasData;
      logic outFull;
      logic inFull;
      logic featDis;
      logic inIrqEn;
      logic [`EBS_DATA_W-1:0] rdData;
      logic rdValid;
      logic wrAck;
   } ebs_state_t;

endpackage : ebs_pkg

// file: tb/ebs_status_props.sv
// Concurrent checks on the status register ports
`timescale 1ns/1ps
`default_nettype none
`include "ebs_defines.svh"
module ebs_status_props (
   input wire logic clk, arst_n, pmDataBkptHit, outFifoHasData, outFifoFull, inRegFull,
   input wire logic emuFeatureDisable, inRegIrqEnable, coreRdEn, coreWrEn, coreRdValid, coreWrAck,
   input wire logic outFifoIrqEnable,
   input wire logic [19:0] coreAddr,
   input wire logic [31:0] coreWrData, coreRdData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_rdst; coreRdEn && coreAddr == `EBS_STATUS_ADDR; endsequence
   sequence s_wrst; coreWrEn && coreAddr == `EBS_STATUS_ADDR; endsequence
   a_rd_latency: assert property (coreRdEn |=> coreRdValid) else $error("read not answered");
   a_pm_hit: assert property (pmDataBkptHit ##[1:4] s_rdst |=> coreRdData[0]) else $error("hit lost");
   a_hit_stick: assert property (
      s_rdst |=> ({$past(coreRdData[16]), $past(coreRdData[7:0])} & ~{coreRdData[16], coreRdData[7:0]}) == 9'h000)
      else $error("hit bit cleared");
   a_mbox_copy: assert property (
      s_rdst |=> coreRdData[15:10] == {$past(inRegIrqEnable, 2), 1'b0,
      $past(emuFeatureDisable, 2), $past(inRegFull, 2), $past(outFifoFull, 2), $past(outFifoHasData, 2)})
      else $error("mailbox bits wrong");
   a_resv_zero: assert property (
      coreRdValid |-> coreRdData[31:17] == 15'h0 && !coreRdData[14] && !coreRdData[8])
      else $error("reserved bit set");
   a_unmapped_zero: assert property (
      coreRdEn && coreAddr != `EBS_STATUS_ADDR |=> coreRdData == 32'h0)
      else $error("unmapped read not zero");
   a_wr_ack: assert property (
      s_wrst |=> coreWrAck && outFifoIrqEnable == $past(coreWrData[9]))
      else $error("write not taken");
   a_irq_read: assert property (
      s_rdst |=> coreRdData[9] == $past(outFifoIrqEnable))
      else $error("enable bit misread");
endmodule : ebs_status_props
bind ebs_status ebs_status_props i_ebs_status_props (.*);
`default_nettype wire

// file: tb/ebs_core_model.sv
// Core side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module ebs_core_model (
   input wire logic clk,
   output logic coreRdEn = 1'b0, coreWrEn = 1'b0,
   output logic [19:0] coreAddr = 20'h0,
   output logic [31:0] coreWrData = 32'h0
);
   // Released address and data lines show the inverse and both enables drop, so stale values never look valid
   task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d);
      @(negedge clk);
      {coreWrEn, coreRdEn, coreAddr, coreWrData} = {w, !w, a, d};
      @(negedge clk);
      {coreWrEn, coreRdEn, coreAddr, coreWrData} = {2'b00, ~a, ~d};
   endtask : acc
endmodule : ebs_core_model
`default_nettype wire

// file: tb/ebs_status_tb.sv
// Self-checking bench for the status register
`timescale 1ns/1ps
`default_nettype none
`include "ebs_defines.svh"
module ebs_status_tb;
   logic clk = 0, arst_n = 0, coreRdEn, coreWrEn, coreRdValid, coreWrAck, outFifoIrqEnable;
   logic [8:0] hit = 9'h0, acc = 9'h0;
   logic [4:0] mb = 5'h0;
   logic [19:0] coreAddr;
   logic [31:0] coreWrData, coreRdData, expQ[$];
   int err_count = 0, compares = 0;
   initial forever #25 clk = ~clk;
   ebs_status i_ebs_status (.clk(clk), .arst_n(arst_n), .pmDataBkptHit(hit[0]), .dmAddr0BkptHit(hit[1]),
      .dmAddr1BkptHit(hit[2]), .instrAddr0BkptHit(hit[3]), .instrAddr1BkptHit(hit[4]), .instrAddr2BkptHit(hit[5]),
      .instrAddr3BkptHit(hit[6]), .periphDmaBkptHit(hit[7]), .extportDmaBkptHit(hit[8]), .outFifoHasData(mb[0]),
      .outFifoFull(mb[1]), .inRegFull(mb[2]), .emuFeatureDisable(mb[3]), .inRegIrqEnable(mb[4]),
      .coreRdEn(coreRdEn), .coreWrEn(coreWrEn), .coreAddr(coreAddr), .coreWrData(coreWrData),
      .coreRdData(coreRdData), .coreRdValid(coreRdValid), .coreWrAck(coreWrAck),
      .outFifoIrqEnable(outFifoIrqEnable));
   ebs_core_model i_ebs_core_model (.clk(clk), .coreRdEn(coreRdEn), .coreWrEn(coreWrEn), .coreAddr(coreAddr),
      .coreWrData(coreWrData));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   function logic [31:0] img(input logic ie);
      return {15'h0, acc[8], mb[4], 1'b0, mb[3:0], ie, 1'b0, acc[7:0]};
   endfunction : img
   task rdq(input logic [19:0] a, input logic [31:0] e);
      expQ.push_back(e);
      i_ebs_core_model.acc(1'b0, a, 32'h0);
   endtask : rdq
   always @(negedge clk) if (coreRdValid === 1'b1) chk("read", expQ.pop_front(), coreRdData);
   initial begin
      #100us;
      err_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(13));
      repeat (5) @(posedge clk);
      @(negedge clk) arst_n = 1;
      rdq(`EBS_STATUS_ADDR, 32'h0);
      rdq(20'h30020, 32'h0);
      $display("test reset done");
      // Walk every hit source once, then random bursts
      for (int i = 0; i < 16; i++) begin
         @(negedge clk) {hit, mb} = {(i < 9) ? 9'h1 << i : 9'($urandom), 5'($urandom)};
         acc |= hit;
         @(negedge clk) hit = 9'h0;
         rdq(`EBS_STATUS_ADDR, img(1'b0));
      end
      $display("test hits done");
      i_ebs_core_model.acc(1'b1, `EBS_STATUS_ADDR, 32'hffff_ffff);
      i_ebs_core_model.acc(1'b1, 20'h30034, 32'h0);
      rdq(`EBS_STATUS_ADDR, img(1'b1));
      chk("irqen", 32'h1, {31'h0, outFifoIrqEnable});
      i_ebs_core_model.acc(1'b1, `EBS_STATUS_ADDR, 32'hffff_fdff);
      rdq(`EBS_STATUS_ADDR, img(1'b0));
      @(negedge clk);
      $display("test write done");
      give_verdict();
   end
endmodule : ebs_status_tb
`default_nettype wire
